// file: rtl/plmg_guard.sv
// privilege level memory guard: per access permit or deny
`timescale 1ns/100ps
module plmg_guard
    import plmg_pkg::*;
#(
    parameter int NUM_AREAS = PLMG_NUM_AREAS,
    parameter int ADDR_W = PLMG_ADDR_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // level tracking from the core
    input wire logic level_load,
    input wire plmg_pkg::plmg_level_t level_new,
    input wire logic irq_enter,
    input wire logic irq_exit,
    input wire plmg_pkg::plmg_level_t irq_level,
    // access request from the core
    input wire logic req_valid,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire plmg_pkg::plmg_op_t req_op,
    input wire logic req_jump,
    input wire plmg_pkg::plmg_level_t req_target_level,
    input wire logic [31:0] req_wdata,
    // access toward the memories
    output logic mem_valid,
    output logic [ADDR_W-1:0] mem_addr,
    output plmg_pkg::plmg_op_t mem_op,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    // answer to the core
    output logic [31:0] rsp_rdata,
    output logic rsp_valid,
    output logic rsp_denied,
    output plmg_pkg::plmg_level_t cur_level,
    // violation toward exception logic
    output logic violation,
    // attribute storage port
    input wire logic cfg_we,
    input wire logic cfg_re,
    input wire logic [$clog2(NUM_AREAS)-1:0] cfg_area,
    input wire logic [1:0] cfg_field,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_err
);
    // ************************************************************
    // state
    // ************************************************************
    localparam logic [1:0] FLD_BASE = 2'h0;
    localparam logic [1:0] FLD_LIMIT = 2'h1;
    localparam logic [1:0] FLD_ATTR = 2'h2;

    plmg_level_t level, next_level, saved_level, next_saved_level;
    logic in_irq, next_in_irq;
    logic [NUM_AREAS-1:0][ADDR_W-1:0] area_base, next_area_base;
    logic [NUM_AREAS-1:0][ADDR_W-1:0] area_limit, next_area_limit;
    logic [NUM_AREAS-1:0][PLMG_ATTR_W-1:0] area_attr, next_area_attr;
    logic [31:0] next_cfg_rdata;
    logic next_cfg_err;
    logic hit, allow, granted, subj_priv;
    logic next_rsp_valid, next_rsp_denied, next_violation, next_mem_valid;
    logic [31:0] next_rsp_rdata;
    logic [ADDR_W-1:0] next_mem_addr;
    logic [31:0] next_mem_wdata;
    logic pend_read, next_pend_read;

    // ************************************************************
    // permission lookup
    // ************************************************************
    plmg_check #(.NUM_AREAS(NUM_AREAS), .ADDR_W(ADDR_W)) u_check (
        .addr(req_addr),
        .level(level),
        .op(req_op),
        .area_base(area_base),
        .area_limit(area_limit),
        .area_attr(area_attr),
        .hit(hit),
        .allow(allow)
    );

    // unmapped addresses are denied: fail closed rather than leak
    // a jump to another level needs execute rights of the current level on the target area
    // and the target level must not be more privileged than the caller
    always_comb begin
        granted = hit && allow;
        if (req_jump && req_target_level != level) begin
            granted = granted && (req_op == PLMG_OP_EXEC)
                && (req_target_level >= level);
        end
    end

    assign subj_priv = (level <= PLMG_PRIV_MAX);

    // ************************************************************
    // current level tracking
    // ************************************************************
    // one nesting level for interrupts; deeper nests need software save
    always_comb begin
        next_level = level;
        next_saved_level = saved_level;
        next_in_irq = in_irq;
        if (irq_enter && !in_irq) begin
            next_saved_level = level;
            next_level = irq_level;
            next_in_irq = 1'b1;
        end else if (irq_exit && in_irq) begin
            next_level = saved_level;
            next_in_irq = 1'b0;
        end else if (level_load && level_new <= PLMG_APP_LEVEL_TWO) begin
            next_level = level_new;
        end
    end

    // ************************************************************
    // attribute storage
    // ************************************************************
    always_comb begin
        next_area_base = area_base;
        next_area_limit = area_limit;
        next_area_attr = area_attr;
        next_cfg_rdata = cfg_rdata;
        next_cfg_err = 1'b0;
        if (cfg_we || cfg_re) begin
            if (!subj_priv) begin
                next_cfg_err = 1'b1;
                next_cfg_rdata = 32'h0;
            end else if (cfg_we) begin
                unique case (cfg_field)
                    FLD_BASE: next_area_base[cfg_area] = cfg_wdata[ADDR_W-1:0];
                    FLD_LIMIT: next_area_limit[cfg_area] = cfg_wdata[ADDR_W-1:0];
                    FLD_ATTR: next_area_attr[cfg_area] = cfg_wdata[PLMG_ATTR_W-1:0];
                    default: next_cfg_err = 1'b1;
                endcase
            end else begin
                unique case (cfg_field)
                    FLD_BASE: next_cfg_rdata = 32'(area_base[cfg_area]);
                    FLD_LIMIT: next_cfg_rdata = 32'(area_limit[cfg_area]);
                    FLD_ATTR: next_cfg_rdata = 32'(area_attr[cfg_area]);
                    default: begin
                        next_cfg_rdata = 32'h0;
                        next_cfg_err = 1'b1;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // access path
    // ************************************************************
    // the memory sees only granted requests, and read data is gated
    // by the same decision, so a denied access yields nothing
    always_comb begin
        next_mem_valid = req_valid && granted;
        next_mem_addr = next_mem_valid ? req_addr : '0;
        next_mem_wdata = next_mem_valid ? req_wdata : 32'h0;
        next_pend_read = req_valid && granted
            && (req_op == PLMG_OP_READ || req_op == PLMG_OP_EXEC);
        next_rsp_valid = req_valid;
        next_rsp_denied = req_valid && !granted;
        next_violation = req_valid && !granted;
        next_rsp_rdata = 32'h0;
        if (pend_read) begin
            next_rsp_rdata = mem_rdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            level <= PLMG_VENDOR_LEVEL;
            saved_level <= PLMG_VENDOR_LEVEL;
            in_irq <= 1'b0;
            for (int i = 0; i < NUM_AREAS; i++) begin
                area_base[i] <= '0;
                area_limit[i] <= '1;
                area_attr[i] <= PLMG_DEFAULT_PERMISSIVE ? PLMG_ATTR_PERMIT
                    : PLMG_ATTR_RESTRICT;
            end
            cfg_rdata <= 32'h0;
            cfg_err <= 1'b0;
            mem_valid <= 1'b0;
            mem_addr <= '0;
            mem_op <= PLMG_OP_READ;
            mem_wdata <= 32'h0;
            pend_read <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_denied <= 1'b0;
            rsp_rdata <= 32'h0;
            violation <= 1'b0;
        end else begin
            level <= next_level;
            saved_level <= next_saved_level;
            in_irq <= next_in_irq;
            area_base <= next_area_base;
            area_limit <= next_area_limit;
            area_attr <= next_area_attr;
            cfg_rdata <= next_cfg_rdata;
            cfg_err <= next_cfg_err;
            mem_valid <= next_mem_valid;
            mem_addr <= next_mem_addr;
            mem_op <= req_op;
            mem_wdata <= next_mem_wdata;
            pend_read <= next_pend_read;
            rsp_valid <= next_rsp_valid;
            rsp_denied <= next_rsp_denied;
            rsp_rdata <= next_rsp_rdata;
            violation <= next_violation;
        end
    end

    assign cur_level = level;
endmodule // plmg_guard

// file: rtl/plmg_pkg.sv
// package of constants and types for the privilege level memory guard
package plmg_pkg;
    // ************************************************************
    // privilege levels
    // ************************************************************
    typedef enum logic [2:0] {
        PLMG_VENDOR_LEVEL = 3'h0,
        PLMG_SYSTEM_LEVEL_ONE = 3'h1,
        PLMG_SYSTEM_LEVEL_TWO = 3'h2,
        PLMG_SHARED_LEVEL = 3'h3,
        PLMG_APP_LEVEL_ONE = 3'h4,
        PLMG_APP_LEVEL_TWO = 3'h5
    } plmg_level_t;

    // ************************************************************
    // operations
    // ************************************************************
    typedef enum logic [1:0] {
        PLMG_OP_READ = 2'h0,
        PLMG_OP_WRITE = 2'h1,
        PLMG_OP_DELETE = 2'h2,
        PLMG_OP_EXEC = 2'h3
    } plmg_op_t;

    localparam int PLMG_NUM_LEVELS = 6;
    localparam int PLMG_NUM_OPS = 4;
    localparam int PLMG_ADDR_W = 24;
    localparam int PLMG_NUM_AREAS = 8;
    localparam int PLMG_ATTR_W = PLMG_NUM_LEVELS * PLMG_NUM_OPS;
    // permission bit index: level * 4 + op
    localparam int PLMG_OP_SHIFT = 2;
    // highest level allowed to touch the attribute storage
    localparam logic [2:0] PLMG_PRIV_MAX = 3'h2;
    // default attributes: 1 = permissive, 0 = restrictive
    localparam logic PLMG_DEFAULT_PERMISSIVE = 1'h0;
    // in restrictive mode privileged levels keep full rights
    localparam logic [23:0] PLMG_ATTR_RESTRICT = 24'h000fff;
    localparam logic [23:0] PLMG_ATTR_PERMIT = 24'hffffff;
endpackage

// file: rtl/plmg_check.sv
// combinational permission lookup for one access
`timescale 1ns/100ps
module plmg_check
    import plmg_pkg::*;
#(
    parameter int NUM_AREAS = PLMG_NUM_AREAS,
    parameter int ADDR_W = PLMG_ADDR_W
) (
    // access
    input wire logic [ADDR_W-1:0] addr,
    input wire plmg_pkg::plmg_level_t level,
    input wire plmg_pkg::plmg_op_t op,
    // area table
    input wire logic [NUM_AREAS-1:0][ADDR_W-1:0] area_base,
    input wire logic [NUM_AREAS-1:0][ADDR_W-1:0] area_limit,
    input wire logic [NUM_AREAS-1:0][PLMG_ATTR_W-1:0] area_attr,
    // result
    output logic hit,
    output logic allow
);
    function automatic logic perm_bit(input logic [PLMG_ATTR_W-1:0] attr,
                                      input logic [2:0] lvl, input logic [1:0] o);
        logic [4:0] idx;
        idx = {lvl, 2'h0} + {3'h0, o};
        perm_bit = attr[idx];
    endfunction

    // lowest matching area wins, so overlaps resolve predictably
    always_comb begin
        hit = 1'b0;
        allow = 1'b0;
        for (int i = NUM_AREAS - 1; i >= 0; i--) begin
            if (addr >= area_base[i] && addr <= area_limit[i]) begin
                hit = 1'b1;
                allow = perm_bit(area_attr[i], level, op);
            end
        end
    end
endmodule // plmg_check

// file: dv/plmg_guard_checker.sv
// assertions on the guard ports
`timescale 1ns/100ps
module plmg_guard_checker
    import plmg_pkg::*;
#(
    parameter int NUM_AREAS = PLMG_NUM_AREAS,
    parameter int ADDR_W = PLMG_ADDR_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // core side
    input wire logic level_load,
    input wire plmg_pkg::plmg_level_t level_new,
    input wire logic irq_enter,
    input wire logic irq_exit,
    input wire logic req_valid,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire plmg_pkg::plmg_op_t req_op,
    input wire logic [31:0] req_wdata,
    input wire logic cfg_we,
    input wire logic cfg_re,
    input wire logic [1:0] cfg_field,
    // guard outputs
    input wire logic mem_valid,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire plmg_pkg::plmg_op_t mem_op,
    input wire logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic [31:0] rsp_rdata,
    input wire logic rsp_valid,
    input wire logic rsp_denied,
    input wire plmg_pkg::plmg_level_t cur_level,
    input wire logic violation,
    input wire logic cfg_err
);
    // *******
    // access, config and level timing
    // *******
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_req; req_valid; endsequence
    sequence s_deny; rsp_valid && rsp_denied; endsequence
    a_rsp_timing: assert property (s_req |=> rsp_valid) else $error("no answer");
    a_rsp_only: assert property (rsp_valid |-> $past(req_valid)) else $error("stray answer");
    a_deny_block: assert property (s_deny |-> violation && !mem_valid) else $error("leak");
    a_viol_only: assert property (violation |-> s_deny) else $error("stray violation");
    a_grant_fwd: assert property (rsp_valid && !rsp_denied |-> mem_valid) else $error("lost");
    a_fwd_addr: assert property (s_req ##1 mem_valid |-> mem_addr == $past(req_addr))
        else $error("address changed");
    a_fwd_data: assert property (s_req ##1 mem_valid |-> mem_wdata == $past(req_wdata)
        && mem_op == $past(req_op)) else $error("forwarded data changed");
    a_deny_empty: assert property (s_deny |=> rsp_rdata == 32'h0) else $error("denied data");
    a_read_data: assert property (mem_valid && mem_op inside {PLMG_OP_READ, PLMG_OP_EXEC}
        |=> rsp_rdata == $past(mem_rdata)) else $error("read data");
    a_cfg_refuse: assert property ((cfg_we || cfg_re)
        && (cur_level > 3'h2 || cfg_field == 2'h3) |=> cfg_err) else $error("config not refused");
    a_cfg_cause: assert property (cfg_err |-> $past(cfg_we) || $past(cfg_re))
        else $error("stray config error");
    a_level_load: assert property (level_load && level_new <= PLMG_APP_LEVEL_TWO
        && !irq_enter && !irq_exit |=> cur_level == $past(level_new))
        else $error("level not loaded");
    a_level_hold: assert property (!level_load && !irq_enter && !irq_exit
        |=> $stable(cur_level)) else $error("level moved");
endmodule // plmg_guard_checker

// file: dv/plmg_mem_model.sv
// far-side memory model answering forwarded accesses
`timescale 1ns/100ps
module plmg_mem_model (
    // clock
    input wire logic clk,
    // access from the guard
    input wire logic mem_valid,
    input wire logic [23:0] mem_addr,
    output logic [31:0] mem_rdata
);
    logic [31:0] last = 32'h0;
    // idle data flips each cycle so stale values never look valid
    always_ff @(posedge clk) last <= ~mem_rdata;
    assign mem_rdata = mem_valid ? ({8'h00, mem_addr} ^ 32'ha5a5a5a5) : last;
endmodule // plmg_mem_model

// file: dv/privilege_level_memory_guard_tb.sv
// self-checking bench for the privilege level memory guard
`timescale 1ns/100ps
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module privilege_level_memory_guard_tb;
    import plmg_pkg::*;
    logic clk = 0, rst_b = 0, level_load = 0, irq_enter = 0, irq_exit = 0, req_valid = 0;
    logic req_jump = 0, cfg_we = 0, cfg_re = 0, mem_valid, rsp_valid, rsp_denied, violation, cfg_err;
    plmg_level_t level_new = PLMG_VENDOR_LEVEL, irq_level = PLMG_VENDOR_LEVEL, cur_level;
    plmg_level_t req_target_level = PLMG_VENDOR_LEVEL;
    plmg_op_t req_op = PLMG_OP_READ, mem_op;
    logic [23:0] req_addr = '0, mem_addr, base [8], lim [8], attr [8];
    logic [2:0] cfg_area = '0, lv = '0;
    logic [1:0] cfg_field = '0;
    logic [31:0] req_wdata = '0, cfg_wdata = '0, mem_wdata, mem_rdata, rsp_rdata, cfg_rdata;
    logic [32:0] expq [$];
    logic [15:0] seed = 16'h001e;
    int mismatches = 0, num_checks = 0;
    always #2.5 clk = ~clk;
    plmg_guard DUT (.clk, .rst_b, .level_load, .level_new, .irq_enter, .irq_exit, .irq_level,
        .req_valid, .req_addr, .req_op, .req_jump, .req_target_level, .req_wdata, .mem_valid,
        .mem_addr, .mem_op, .mem_wdata, .mem_rdata, .rsp_rdata, .rsp_valid, .rsp_denied,
        .cur_level, .violation, .cfg_we, .cfg_re, .cfg_area, .cfg_field, .cfg_wdata, .cfg_rdata,
        .cfg_err);
    plmg_mem_model u_mem (.clk, .mem_valid, .mem_addr, .mem_rdata);
    // *******
    // helpers
    // *******
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic deny(logic [23:0] a, logic [1:0] o, logic j, logic [2:0] t);
        for (int i = 0; i < 8; i++)
            if (a >= base[i] && a <= lim[i])
                return !attr[i][lv * 4 + o] || (j && t != lv && (o != 2'h3 || t < lv));
        return 1'h1;
    endfunction
    // strobes are set once per step, so back to back pulses never glitch low
    task step(input logic [5:0] strobes = 6'h00);
        @(posedge clk);
        #1;
        {level_load, irq_enter, irq_exit, req_valid, cfg_we, cfg_re} = strobes;
    endtask
    task lset(input logic [2:0] l);
        step(6'h20);
        level_new = plmg_level_t'(l);
        lv = l;
    endtask
    task acc(input logic [23:0] a, input logic [1:0] o, input logic j, input logic [2:0] t);
        logic d;
        d = deny(a, o, j, t);
        step(6'h04);
        {req_addr, req_jump} = {a, j};
        req_op = plmg_op_t'(o);
        req_target_level = plmg_level_t'(t);
        req_wdata = {seed, seed};
        expq.push_back({d, (d || o == 2'h1 || o == 2'h2) ? 32'h0 : {8'h00, a} ^ 32'ha5a5a5a5});
    endtask
    task cfg(input logic w, input logic [2:0] ar, input logic [1:0] f, input logic [31:0] dt,
        input logic e);
        logic [31:0] x;
        x = e ? 32'h0 : {8'h00, f == 2'h0 ? base[ar] : f == 2'h1 ? lim[ar] : attr[ar]};
        step({4'h0, w, !w});
        {cfg_area, cfg_field, cfg_wdata} = {ar, f, dt};
        step();
        `CHK("cfg_err", e, cfg_err)
        if (!w) `CHK("cfg_rdata", x, cfg_rdata)
        if (w && !e && f == 2'h0) base[ar] = dt[23:0];
        if (w && !e && f == 2'h1) lim[ar] = dt[23:0];
        if (w && !e && f == 2'h2) attr[ar] = dt[23:0];
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // *******
    // result watcher
    // *******
    initial begin
        logic [32:0] e;
        logic pend;
        pend = 1'h0;
        forever begin
            step_wait: @(posedge clk);
            #1;
            if (pend) `CHK("rsp_rdata", e[31:0], rsp_rdata)
            pend = 1'h0;
            if (rsp_valid === 1'h1) begin
                e = expq.size() ? expq.pop_front() : '1;
                `CHK("rsp_denied", e[32], rsp_denied)
                `CHK("violation", e[32], violation)
                pend = 1'h1;
            end
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done;
    end
    // *******
    // scenarios
    // *******
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst_b = 1'h1;
        for (int i = 0; i < 8; i++) begin
            {base[i], lim[i]} = {24'h000000, 24'hffffff};
            attr[i] = PLMG_DEFAULT_PERMISSIVE ? PLMG_ATTR_PERMIT : PLMG_ATTR_RESTRICT;
        end
        for (int l = 0; l < 6; l++) begin
            lset(3'(l));
            for (int o = 0; o < 4; o++) begin
                seed = lfsr(seed);
                acc({seed, seed[7:0]}, 2'(o), 1'h0, 3'h0);
            end
        end
        $display("test defaults done");
        lset(3'h0);
        cfg(1'h1, 3'h0, 2'h2, {8'h00, seed, seed[15:8]}, 1'h0);
        cfg(1'h0, 3'h0, 2'h2, '0, 1'h0);
        cfg(1'h1, 3'h0, 2'h1, 32'h000000ff, 1'h0);
        cfg(1'h1, 3'h1, 2'h0, 32'h00000100, 1'h0);
        cfg(1'h1, 3'h1, 2'h1, 32'h000001ff, 1'h0);
        cfg(1'h1, 3'h1, 2'h2, 32'h00000000, 1'h0);
        cfg(1'h0, 3'h1, 2'h3, '0, 1'h1);
        for (int i = 0; i < 60; i++) begin
            seed = lfsr(seed);
            if (seed[1:0] == 2'h0) lset(3'(seed[15:8] % 6));
            acc({14'h0, seed[9:0]}, seed[11:10], seed[12], 3'(seed[15:13] % 6));
        end
        $display("test areas done");
        lset(3'h0);
        cfg(1'h1, 3'h0, 2'h2, 32'h00ffffff, 1'h0);
        lset(3'h1);
        for (int t = 0; t < 12; t++) acc(24'h10, t[0] ? 2'h3 : 2'h0, 1'h1, 3'(t / 2));
        $display("test jumps done");
        lset(3'h4);
        cfg(1'h1, 3'h0, 2'h2, '0, 1'h1);
        cfg(1'h0, 3'h0, 2'h2, '0, 1'h1);
        acc(24'h10, 2'h1, 1'h0, 3'h4);
        step(6'h10);
        irq_level = PLMG_SYSTEM_LEVEL_TWO;
        lv = 3'h2;
        step();
        `CHK("cur_level", 3'h2, cur_level)
        // nested entry and an illegal level code must both be ignored
        step(6'h10);
        irq_level = PLMG_VENDOR_LEVEL;
        step(6'h20);
        level_new = plmg_level_t'(3'h7);
        step();
        `CHK("cur_level", 3'h2, cur_level)
        cfg(1'h1, 3'h2, 2'h2, '0, 1'h0);
        acc(24'h250, 2'h0, 1'h0, 3'h2);
        step(6'h08);
        lv = 3'h4;
        step();
        `CHK("cur_level", 3'h4, cur_level)
        acc(24'h250, 2'h3, 1'h0, 3'h4);
        $display("test levels done");
        repeat (4) step();
        `CHK("pending", 0, expq.size())
        test_done;
    end
endmodule // privilege_level_memory_guard_tb
bind plmg_guard plmg_guard_checker #(.NUM_AREAS(NUM_AREAS), .ADDR_W(ADDR_W)) u_chk (.clk,
    .rst_b, .level_load, .level_new, .irq_enter, .irq_exit, .req_valid, .req_addr, .req_op,
    .req_wdata, .cfg_we, .cfg_re, .cfg_field, .mem_valid, .mem_addr, .mem_op, .mem_wdata,
    .mem_rdata, .rsp_rdata, .rsp_valid,
    .rsp_denied, .cur_level, .violation, .cfg_err);
